// *** logic/wdsw_top.sv ***
module wdsw_top import wdsw_pkg::*; #(
  parameter int unsigned WDT_BASE = WDT_BASE_CYCLES, // shorten for simulation
  parameter int unsigned IO_W = 8
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic wdt_osc_i,
  input wire logic master_clear_pin_n_i,
  input wire logic watchdog_enable_fuse_i,
  input wire logic clear_watchdog_instr_i,
  input wire logic sleep_instr_i,
  input wire logic option_wr_i,
  input wire logic [7:0] option_wdata_i,
  input wire logic timer_tick_i,
  input wire logic [IO_W-1:0] io_out_i,
  input wire logic [IO_W-1:0] io_oe_i,
  output logic [7:0] prescaler_config_o,
  output logic [7:0] status_flags_o,
  output logic device_reset_o,
  output logic sleep_o,
  output logic main_osc_en_o,
  output logic timer_tick_o,
  output logic [IO_W-1:0] io_out_o,
  output logic [IO_W-1:0] io_oe_o
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks

  // base count must fit the counter and allow a wrap
  if (WDT_BASE < 2 || WDT_BASE > (1 << WDT_BASE_W)) begin : g_bad_base
    $error("watchdog base count out of range");
  end
  if (IO_W < 1) begin : g_bad_io
    $error("io width must be at least one");
  end

  localparam logic [WDT_BASE_W-1:0] BASE_LAST = WDT_BASE_W'(WDT_BASE - 1);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  wdsw_pwr_e pwr_q; // run or asleep
  logic fuse_q; // captured enable fuse
  logic fuse_done_q; // fuse captured once after release
  logic mclr_s; // synchronised pin, low means reset
  logic mclr_low; // external reset asserted
  logic [2:0] rst_cnt_q; // device reset stretch counter
  logic dev_rst; // device reset in progress
  logic reset_req; // master clear or time-out
  logic sleep_go; // sleep instruction taken
  logic clr_go; // clear instruction taken
  logic wd_clear; // any cause that clears the watchdog
  logic clr_tgl_q; // clear request toggle towards watchdog domain
  logic clr_redo_q; // clear asked while one still in flight
  logic clr_pending; // clear not yet echoed back
  logic ovf_s; // synchronised overflow toggle
  logic ack_s; // synchronised clear echo
  logic ovf_seen_q; // last overflow toggle seen
  logic ovf_evt; // one base period elapsed
  logic ovf_ok; // usable overflow
  logic [7:0] pcfg_q; // prescaler configuration
  logic divider_assign_sel; // divider assigned to watchdog
  logic [RATIO_W-1:0] ratio; // ratio field
  logic [DIV_W-1:0] div_q; // shared divider
  logic [DIV_W-1:0] div_last; // terminal count
  logic div_evt; // divider input event
  logic div_hit; // divider wrapped
  logic div_clr; // divider cleared
  logic cfg_wr; // accepted configuration write
  logic wdt_timeout; // watchdog fired
  logic to_q; // time-out flag, active low meaning
  logic pd_q; // power-down flag, active low meaning
  logic tick_q; // timer tick out
  logic [IO_W-1:0] io_out_q; // held pin levels
  logic [IO_W-1:0] io_oe_q; // held pin enables
  logic clr_s; // clear toggle in watchdog domain
  logic fuse_s; // fuse level in watchdog domain
  logic [WDT_BASE_W-1:0] base_q; // watchdog base counter
  logic clr_seen_q; // last clear toggle taken
  logic ovf_tgl_q; // overflow toggle towards core
  logic ack_tgl_q; // clear echo towards core

  ////////////////////////////////////////////////////////////////////////////
  // watchdog oscillator domain

  // clear toggle and fuse level cross into the oscillator domain
  wdsw_sync #(.W(2), .RST_VAL(2'h0)) u_wsync (
    .clk_i(wdt_osc_i),
    .rst_i(sys_rst_i),
    .d_i({clr_tgl_q, fuse_q}),
    .q_o({clr_s, fuse_s})
  );

  // base counter on the free oscillator, keeps running while the core sleeps
  always_ff @(posedge wdt_osc_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      base_q <= '0;
      clr_seen_q <= 1'b0;
      ovf_tgl_q <= 1'b0;
      ack_tgl_q <= 1'b0;
    end else if (clr_s != clr_seen_q) begin // clear request arrived
      clr_seen_q <= clr_s;
      ack_tgl_q <= clr_s;
      base_q <= '0;
    end else if (!fuse_s) begin // disabled: parked at zero
      base_q <= '0;
    end else if (base_q == BASE_LAST) begin // one base period
      base_q <= '0;
      ovf_tgl_q <= ~ovf_tgl_q;
    end else begin
      base_q <= base_q + WDT_BASE_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin and event synchronisation into core clock

  // pin reset value is high, i.e. not asserted
  wdsw_sync #(.W(1), .RST_VAL(1'b1)) u_msync (
    .clk_i(clk_i),
    .rst_i(sys_rst_i),
    .d_i(master_clear_pin_n_i),
    .q_o(mclr_s)
  );

  // overflow and clear echo back into the core domain
  wdsw_sync #(.W(2), .RST_VAL(2'h0)) u_csync (
    .clk_i(clk_i),
    .rst_i(sys_rst_i),
    .d_i({ovf_tgl_q, ack_tgl_q}),
    .q_o({ovf_s, ack_s})
  );

  assign mclr_low = ~mclr_s;

  // overflow toggle edge detect on the second stage
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ovf_seen_q <= 1'b0;
    end else begin
      ovf_seen_q <= ovf_s;
    end
  end

  assign ovf_evt = ovf_s ^ ovf_seen_q;
  // an overflow issued before a clear arrives no later than its echo, so drop it
  assign clr_pending = clr_tgl_q != ack_s;
  assign ovf_ok = ovf_evt && !clr_pending && fuse_q && !dev_rst;

  ////////////////////////////////////////////////////////////////////////////
  // fuse capture

  // nonvolatile bit is static; caught once after reset release
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fuse_q <= 1'b0;
      fuse_done_q <= 1'b0;
    end else if (!fuse_done_q) begin
      fuse_q <= watchdog_enable_fuse_i;
      fuse_done_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // device reset and power state

  // internal reset only; the master-clear pin is an input and is never driven
  assign reset_req = mclr_low || wdt_timeout;

  // stretch every reset request by four cycles past its end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rst_cnt_q <= RST_PULSE_CYCLES;
    end else if (reset_req) begin
      rst_cnt_q <= RST_PULSE_CYCLES;
    end else if (rst_cnt_q != 3'h0) begin
      rst_cnt_q <= rst_cnt_q - 3'h1;
    end
  end

  assign dev_rst = rst_cnt_q != 3'h0;
  assign sleep_go = sleep_instr_i && pwr_q == WDSW_RUN && !dev_rst && !reset_req;
  assign clr_go = clear_watchdog_instr_i && pwr_q == WDSW_RUN && !dev_rst && !reset_req;
  assign wd_clear = clr_go || sleep_go || reset_req;

  // sleep entry and wake; only reset requests wake
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pwr_q <= WDSW_RUN;
    end else begin
      case (pwr_q)
        WDSW_RUN: begin
          if (sleep_go) begin
            pwr_q <= WDSW_SLEEP;
          end
        end
        WDSW_SLEEP: begin
          if (reset_req) begin
            pwr_q <= WDSW_RUN;
          end
        end
        default: pwr_q <= WDSW_RUN;
      endcase
    end
  end

  // clear handshake; a clear during one in flight is replayed after the echo
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      clr_tgl_q <= 1'b0;
      clr_redo_q <= 1'b0;
    end else if (clr_pending) begin
      clr_redo_q <= clr_redo_q || wd_clear;
    end else if (wd_clear || clr_redo_q) begin
      clr_tgl_q <= ~clr_tgl_q;
      clr_redo_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescaler configuration register

  assign cfg_wr = option_wr_i && pwr_q == WDSW_RUN && !dev_rst && !reset_req;

  // write-only from the core, reloaded on every reset
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pcfg_q <= PCFG_RESET;
    end else if (reset_req) begin
      pcfg_q <= PCFG_RESET;
    end else if (cfg_wr) begin
      pcfg_q <= option_wdata_i & PCFG_IMPL_MASK;
    end
  end

  assign divider_assign_sel = pcfg_q[PCFG_ASSIGN_BIT];
  assign ratio = pcfg_q[PCFG_RATIO_LSB +: RATIO_W];

  ////////////////////////////////////////////////////////////////////////////
  // shared divider

  // watchdog gets 1..128, timer gets 2..256; the 8-bit shift wraps to ff at 256
  always_comb begin
    if (divider_assign_sel) begin
      div_last = (8'h01 << ratio) - 8'h01;
    end else begin
      div_last = (8'h02 << ratio) - 8'h01;
    end
  end

  assign div_evt = divider_assign_sel ? ovf_ok : timer_tick_i;
  // at or past the terminal count, so a ratio cut mid-count cannot stretch to a full wrap
  assign div_hit = div_evt && div_q >= div_last;
  // cleared with the watchdog only when assigned to it, and on reassignment
  assign div_clr = (divider_assign_sel && wd_clear) ||
                   (cfg_wr && option_wdata_i[PCFG_ASSIGN_BIT] != divider_assign_sel);

  // one counter, one user at a time
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      div_q <= '0;
    end else if (div_clr) begin
      div_q <= '0;
    end else if (div_evt) begin
      div_q <= div_hit ? '0 : div_q + 8'h01;
    end
  end

  // time-out: undivided when the timer owns the divider
  assign wdt_timeout = divider_assign_sel ? div_hit : ovf_ok;

  // timer tick passes undivided while the watchdog owns the divider
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= divider_assign_sel ? timer_tick_i : div_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags

  // time-out beats a same-cycle clear so the cause is never lost
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      to_q <= TO_POR;
      pd_q <= PD_POR;
    end else if (wdt_timeout) begin
      to_q <= 1'b0;
    end else if (sleep_go) begin
      to_q <= 1'b1;
      pd_q <= 1'b0;
    end else if (clr_go) begin
      to_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin hold

  // pins float during reset, freeze in sleep, follow the core otherwise
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      io_out_q <= '0;
      io_oe_q <= '0;
    end else if (reset_req || dev_rst) begin
      io_oe_q <= '0;
    end else if (pwr_q == WDSW_RUN && !sleep_go) begin
      io_out_q <= io_out_i;
      io_oe_q <= io_oe_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prescaler_config_o = pcfg_q;
  assign status_flags_o = 8'(({7'h00, to_q} << STATUS_TO_BIT) | ({7'h00, pd_q} << STATUS_PD_BIT));
  assign device_reset_o = dev_rst;
  assign sleep_o = pwr_q == WDSW_SLEEP;
  assign main_osc_en_o = pwr_q == WDSW_RUN;
  assign timer_tick_o = tick_q;
  assign io_out_o = io_out_q;
  assign io_oe_o = io_oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  property p_fuse_off;
    @(posedge clk_i) disable iff (sys_rst_i) fuse_done_q && !fuse_q |-> !wdt_timeout;
  endproperty
  a_fuse_off: assert property (p_fuse_off) else $error("time-out with fuse off");

  property p_base_park;
    @(posedge wdt_osc_i) disable iff (sys_rst_i) !fuse_s && clr_s == clr_seen_q |=> base_q == '0;
  endproperty
  a_base_park: assert property (p_base_park) else $error("base counter ran disabled");

  property p_to_clear;
    @(posedge clk_i) disable iff (sys_rst_i) wdt_timeout |=> !status_flags_o[STATUS_TO_BIT];
  endproperty
  a_to_clear: assert property (p_to_clear) else $error("time-out flag not cleared");

  property p_tmo_reset;
    @(posedge clk_i) disable iff (sys_rst_i) wdt_timeout |=> device_reset_o [*4];
  endproperty
  a_tmo_reset: assert property (p_tmo_reset) else $error("time-out reset too short");

  property p_sleep_entry;
    @(posedge clk_i) disable iff (sys_rst_i)
      sleep_go |=> status_flags_o[STATUS_TO_BIT] && !status_flags_o[STATUS_PD_BIT] &&
                   !main_osc_en_o;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("bad sleep entry");

  property p_pin_hold;
    @(posedge clk_i) disable iff (sys_rst_i)
      sleep_o && !reset_req && !dev_rst |=> $stable(io_out_o) && $stable(io_oe_o);
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("pin moved in sleep");

  property p_wake;
    @(posedge clk_i) disable iff (sys_rst_i)
      sleep_o && mclr_low |=> !sleep_o && device_reset_o ##1 clr_pending || clr_redo_q;
  endproperty
  a_wake: assert property (p_wake) else $error("master clear did not wake");

  property p_cfg_reset;
    @(posedge clk_i) disable iff (sys_rst_i) reset_req |=> prescaler_config_o == PCFG_RESET;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset) else $error("config not reloaded");

  property p_pd_fall;
    @(posedge clk_i) disable iff (sys_rst_i) $fell(pd_q) |-> $past(sleep_go);
  endproperty
  a_pd_fall: assert property (p_pd_fall) else $error("power-down flag cleared without sleep");

  property p_div_clear;
    @(posedge clk_i) disable iff (sys_rst_i) divider_assign_sel && clr_go |=> div_q == '0;
  endproperty
  a_div_clear: assert property (p_div_clear) else $error("divider not cleared");

  property p_timer_direct;
    @(posedge clk_i) disable iff (sys_rst_i) divider_assign_sel && timer_tick_i |=> timer_tick_o;
  endproperty
  a_timer_direct: assert property (p_timer_direct) else $error("timer tick lost");

endmodule // wdsw_top

// *** logic/wdsw_pkg.sv ***
// Contract
// - watchdog counts on its own free oscillator
// - watchdog time-out resets device, also in sleep
// - time-out reset clears status bit 4 flag
// - fuse at zero disables watchdog for good
// - one divider serves timer or watchdog, never both
// - assign bit and ratio sit in bits 3:0
// - base time-out 18 ms, times ratio up to 128
// - clear instruction clears watchdog and assigned divider
// - sleep instruction clears watchdog and assigned divider
// - sleep sets time-out flag, clears power-down, stops oscillator
// - pins hold their pre-sleep state while asleep
// - watchdog reset never drives master-clear pin
// - only master-clear or time-out wake, both reset
// - watchdog cleared on every wake from sleep
// - power-down flag set at power-up, cleared by sleep
// - config resets to 3f, upper bits read zero
package wdsw_pkg;

  // main clock and watchdog oscillator timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned WDT_OSC_PERIOD_NS = 50; // nominal, the oscillator drifts widely
  localparam int unsigned WDT_TIMEOUT_US = 18000; // undivided nominal period
  localparam int unsigned WDT_BASE_CYCLES = WDT_TIMEOUT_US * 1000 / WDT_OSC_PERIOD_NS;
  localparam int unsigned WDT_BASE_W = 20; // wide enough for the base count

  // shared divider
  localparam int unsigned DIV_W = 8;
  localparam int unsigned RATIO_W = 3;

  // prescaler configuration register layout
  localparam logic [7:0] PCFG_RESET = 8'h3f; // value after every reset
  localparam logic [7:0] PCFG_IMPL_MASK = 8'h3f; // bits 7:6 unimplemented
  localparam int unsigned PCFG_ASSIGN_BIT = 3; // one: divider on the watchdog
  localparam int unsigned PCFG_RATIO_LSB = 0;

  // status flag positions and power-up values
  localparam int unsigned STATUS_TO_BIT = 4;
  localparam int unsigned STATUS_PD_BIT = 3;
  localparam logic TO_POR = 1'b1;
  localparam logic PD_POR = 1'b1;

  // internal device reset stretch
  localparam logic [2:0] RST_PULSE_CYCLES = 3'h4;

  // power state
  typedef enum logic {
    WDSW_RUN,
    WDSW_SLEEP
  } wdsw_pwr_e;

endpackage

// *** logic/wdsw_sync.sv ***
// two-stage synchroniser, the first stage feeds only the second
module wdsw_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_q; // may go metastable, read by q_q alone
  logic [W-1:0] q_q;

  // both stages reset to a constant
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= RST_VAL;
      q_q <= RST_VAL;
    end else begin
      meta_q <= d_i;
      q_q <= meta_q;
    end
  end

  assign q_o = q_q;

endmodule // wdsw_sync

// *** tb/wdsw_top_bench.sv ***
module wdsw_top_bench;
  timeunit 1ns;
  timeprecision 1ns;

  // short base count keeps every time-out within a few hundred cycles
  localparam int unsigned BASE = 16;
  localparam int LIMIT = 20000; // whole run needs well under 2000 cycles

  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic wdt_osc_i = 1'b0; // 40 ns period, drifts against the core clock
  logic mclr_n = 1'b1;
  logic fuse = 1'b1;
  logic clr = 1'b0;
  logic slp = 1'b0;
  logic owr = 1'b0;
  logic [7:0] owd = 8'h00;
  logic tick_i = 1'b0;
  logic [7:0] io_out_i = 8'h00;
  logic [7:0] io_oe_i = 8'h00;
  logic [7:0] cfg, status, io_out_o, io_oe_o;
  logic dev_rst, sleep, osc_en, tick_o;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int ticks_seen = 0;
  int n, i, m;
  logic [7:0] cfg_tab [6] = '{8'h00, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b};
  int mult_tab [6] = '{1, 1, 1, 2, 4, 8};

  wdsw_top #(.WDT_BASE(BASE), .IO_W(8)) dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .wdt_osc_i(wdt_osc_i),
    .master_clear_pin_n_i(mclr_n), .watchdog_enable_fuse_i(fuse),
    .clear_watchdog_instr_i(clr), .sleep_instr_i(slp), .option_wr_i(owr),
    .option_wdata_i(owd), .timer_tick_i(tick_i), .io_out_i(io_out_i),
    .io_oe_i(io_oe_i), .prescaler_config_o(cfg), .status_flags_o(status),
    .device_reset_o(dev_rst), .sleep_o(sleep), .main_osc_en_o(osc_en),
    .timer_tick_o(tick_o), .io_out_o(io_out_o), .io_oe_o(io_oe_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // clocks, cycle and timer pulse counters
  always #25 clk_i = ~clk_i;
  always #20 wdt_osc_i = ~wdt_osc_i;

  // hang guard, counts as a mismatch
  always @(posedge clk_i) begin
    cycles++;
    if (tick_o === 1'b1) begin
      ticks_seen++;
    end
    if (cycles == LIMIT) begin
      errors++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // comparison and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // core side pulses, one cycle each, launched on a rising edge
  task automatic do_clear();
    @(posedge clk_i) clr <= 1'b1;
    @(posedge clk_i) clr <= 1'b0;
  endtask

  task automatic do_sleep();
    @(posedge clk_i) slp <= 1'b1;
    @(posedge clk_i) slp <= 1'b0;
  endtask

  task automatic wr_cfg(input logic [7:0] d);
    @(posedge clk_i) begin
      owr <= 1'b1;
      owd <= d;
    end
    @(posedge clk_i) owr <= 1'b0;
  endtask

  task automatic ticks(input int k);
    repeat (k) begin
      @(posedge clk_i) tick_i <= 1'b1;
      @(posedge clk_i) tick_i <= 1'b0;
    end
    repeat (3) @(posedge clk_i);
  endtask

  // bounded wait for the internal reset; n equals lim if none came
  task automatic wait_reset(input int lim, output int cnt);
    cnt = 0;
    while (dev_rst !== 1'b1 && cnt < lim) begin
      @(negedge clk_i); // look where the reset output has settled
      cnt++;
    end
  endtask

  // instructions are only taken once the reset stretch is over
  task automatic wait_idle();
    int k;
    k = 0;
    while (dev_rst !== 1'b0 && k < 30) begin
      @(negedge clk_i);
      k++;
    end
  endtask

  task automatic power_on();
    @(posedge clk_i) sys_rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    wait_idle();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i) chk(dev_rst, 1'b1); // stretch still running
    @(negedge clk_i) chk(dev_rst, 1'b0);
    chk(cfg, 8'h3f);
    chk(status, 8'h18);
    chk({sleep, osc_en}, 2'b01);
    // upper bits never stored
    wr_cfg(8'hff);
    @(negedge clk_i) chk(cfg, 8'h3f);
    // regular clears keep an undivided watchdog quiet
    wr_cfg(8'h08);
    repeat (10) begin
      do_clear();
      wait_reset(8, n);
      chk(n, 8);
    end
    chk(status, 8'h18);
    // time-out period against watchdog ratios 1, 2, 4 and 8 and both assignments
    for (i = 0; i < 6; i++) begin
      wait_idle();
      wr_cfg(cfg_tab[i]);
      do_clear();
      m = mult_tab[i];
      wait_reset(m * 13 + 12, n);
      chk(n >= m * 12 && n <= m * 13 + 10, 1);
      chk(status, 8'h08);
      repeat (2) @(negedge clk_i);
      chk(cfg, 8'h3f);
    end
    // sleep freezes pins, then the watchdog wakes the device
    wait_idle();
    @(posedge clk_i) begin
      io_out_i <= 8'h3c;
      io_oe_i <= 8'ha5;
    end
    wr_cfg(8'h0a);
    do_sleep();
    @(negedge clk_i) chk({sleep, osc_en}, 2'b10);
    chk(status, 8'h10);
    @(posedge clk_i) begin
      io_out_i <= 8'h5a;
      io_oe_i <= 8'h0f;
    end
    repeat (2) @(negedge clk_i);
    chk({io_out_o, io_oe_o}, 16'h3ca5);
    wait_reset(80, n);
    chk(n + 3 >= 48 && n + 3 <= 62, 1);
    chk(sleep, 1'b0);
    chk(status, 8'h00);
    // fuse at zero: no time-out in run or in sleep
    @(posedge clk_i) fuse <= 1'b0;
    power_on();
    wr_cfg(8'h00);
    wait_reset(200, n);
    chk(n, 200);
    // divider on the timer: one pulse per four ticks
    wr_cfg(8'h01);
    m = ticks_seen;
    ticks(8);
    chk(ticks_seen - m, 2);
    // divider on the watchdog leaves the timer undivided
    wr_cfg(8'h08);
    m = ticks_seen;
    ticks(3);
    chk(ticks_seen - m, 3);
    do_sleep();
    wait_reset(200, n);
    chk(n, 200);
    // external pin wakes, flags keep the sleep record
    @(posedge clk_i) mclr_n <= 1'b0;
    wait_reset(8, n);
    chk(n < 8, 1);
    @(posedge clk_i) mclr_n <= 1'b1;
    @(negedge clk_i) chk(sleep, 1'b0);
    chk(status, 8'h10);
    chk(cfg, 8'h3f);
    wait_idle();
    chk(osc_en, 1'b1);
    stop_test();
  end

endmodule // wdsw_top_bench
